// File: hw/dvs_top.sv
// Design decisions made here: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Top bit picks low or high range
// - All-zero code gives standby, output disabled
// - Low codes 1..4 give ascending low levels
// - High codes 8..b give ascending high levels
// - Separate fields per channel in first register
// - Address 0001000 or 0001001 by pin
// - Direction bit one reads, zero writes
module dvs_top (
    input wire logic clk,
    input wire logic srst,
    // Serial bus pins, sampled on clk
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic addr_pin,
    // Per-channel supply controls
    output logic [1:0] channel_supply_output,
    output logic [1:0] range_high,
    output logic [3:0] level_index_a,
    output logic [3:0] level_index_b,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    //////////////////////////////////////////////////////////////////////////
    // State record
    typedef struct packed {
        dvs_pkg::dvs_state_t fsm;  // Serial slave state
        logic scl_d;               // Previous clock level
        logic sda_d;               // Previous data level
        logic [7:0] shift;         // Shift register
        logic [2:0] bitc;          // Bit counter
        logic rd;                  // Current transfer is a read
        logic got_idx;             // Sub-address byte already received
        logic [7:0] idx;           // Register index
        logic [7:0] sel;           // First data register
        logic drive_low;           // Pull data line low
        logic cfg_en;              // Serial port enable
        logic [7:0] wr_count;      // Serial data writes to the first data register
        logic aw_hold;             // Write address captured
        logic [3:0] aw_addr;       // Captured write address
        logic w_hold;              // Write data captured
        logic [31:0] w_data;       // Captured write data
        logic [3:0] w_strb;        // Captured byte enables
        logic bvalid;              // Write response pending
        logic [1:0] bresp;         // Write response code
        logic rvalid;              // Read data pending
        logic [31:0] rdata;        // Read data
        logic [1:0] rresp;         // Read response code
    } dvs_regs_t;

    dvs_regs_t r_r;
    dvs_regs_t r_nxt;

    // Bus edge and condition detection
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic addr_match;
    logic [6:0] my_addr;

    assign scl_rise = scl_in & ~r_r.scl_d;
    assign scl_fall = ~scl_in & r_r.scl_d;
    assign start_cond = scl_in & r_r.scl_d & r_r.sda_d & ~sda_in;
    assign stop_cond = scl_in & r_r.scl_d & ~r_r.sda_d & sda_in;
    assign my_addr = addr_pin ? dvs_pkg::ADDR_PIN_HIGH : dvs_pkg::ADDR_PIN_LOW;
    // Address byte holds the seven address bits above the direction bit
    assign addr_match = (r_r.shift[7:1] == my_addr);

    //////////////////////////////////////////////////////////////////////////
    // Per-channel decode of the voltage select field
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_chan
            logic [3:0] code;
            logic valid_low;
            logic valid_high;
            assign code = r_r.sel[ch*dvs_pkg::FIELD_W +: dvs_pkg::FIELD_W];
            // Low range codes in ascending order
            assign valid_low = (code >= dvs_pkg::CODE_LOW_MIN) && (code <= dvs_pkg::CODE_LOW_MAX);
            // High range codes in ascending order
            assign valid_high = (code >= dvs_pkg::CODE_HIGH_MIN) && (code <= dvs_pkg::CODE_HIGH_MAX);
            // Standby and reserved codes keep the output off
            assign channel_supply_output[ch] = valid_low | valid_high;
            // Range follows the top bit of the field for valid codes only, low for standby and reserved codes
            assign range_high[ch] = code[dvs_pkg::RANGE_BIT] & (valid_low | valid_high);
        end
    endgenerate

    // Level index within range: 0 lowest .. 3 highest, zero when disabled
    always_comb begin
        level_index_a = 4'h0;
        level_index_b = 4'h0;
        if (g_chan[0].valid_low) begin
            level_index_a = g_chan[0].code - dvs_pkg::CODE_LOW_MIN;
        end else if (g_chan[0].valid_high) begin
            level_index_a = g_chan[0].code - dvs_pkg::CODE_HIGH_MIN;
        end
        if (g_chan[1].valid_low) begin
            level_index_b = g_chan[1].code - dvs_pkg::CODE_LOW_MIN;
        end else if (g_chan[1].valid_high) begin
            level_index_b = g_chan[1].code - dvs_pkg::CODE_HIGH_MIN;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        r_nxt = r_r;
        r_nxt.scl_d = scl_in;
        r_nxt.sda_d = sda_in;

        // Serial slave
        if (!r_r.cfg_en || stop_cond) begin
            // Stop or disable returns to idle
            r_nxt.fsm = dvs_pkg::DVS_IDLE;
            r_nxt.drive_low = 1'b0;
        end else if (start_cond) begin
            // Start or repeated start begins an address byte
            r_nxt.fsm = dvs_pkg::DVS_ADDR;
            r_nxt.bitc = 3'h0;
            // Clear leftovers so the fall right after start is not taken as a full byte
            r_nxt.shift = 8'h00;
            r_nxt.got_idx = 1'b0;
            r_nxt.drive_low = 1'b0;
        end else begin
            case (r_r.fsm)
                dvs_pkg::DVS_IDLE: begin
                    r_nxt.drive_low = 1'b0;
                end
                dvs_pkg::DVS_ADDR: begin
                    if (scl_rise) begin
                        r_nxt.shift = {r_r.shift[6:0], sda_in};
                        r_nxt.bitc = r_r.bitc + 3'h1;
                    end
                    if (scl_fall && r_r.bitc == 3'h0 && r_r.shift != 8'h00) begin
                        // Eight bits in: address in upper seven, direction last
                        if (addr_match) begin
                            r_nxt.rd = (r_r.shift[0] == dvs_pkg::DIR_READ);
                            r_nxt.drive_low = 1'b1;
                            r_nxt.fsm = dvs_pkg::DVS_ADDR_ACK;
                        end else begin
                            r_nxt.fsm = dvs_pkg::DVS_IDLE;
                        end
                    end
                end
                dvs_pkg::DVS_ADDR_ACK: begin
                    if (scl_fall) begin
                        r_nxt.bitc = 3'h0;
                        if (r_r.rd) begin
                            // Read: present register MSB first
                            r_nxt.shift = r_r.sel;
                            r_nxt.drive_low = ~r_r.sel[7];
                            r_nxt.fsm = dvs_pkg::DVS_RBYTE;
                        end else begin
                            r_nxt.drive_low = 1'b0;
                            r_nxt.fsm = dvs_pkg::DVS_WBYTE;
                        end
                    end
                end
                dvs_pkg::DVS_WBYTE: begin
                    if (scl_rise) begin
                        r_nxt.shift = {r_r.shift[6:0], sda_in};
                        r_nxt.bitc = r_r.bitc + 3'h1;
                        if (r_r.bitc == 3'h7) begin
                            r_nxt.fsm = dvs_pkg::DVS_WACK;
                        end
                    end
                end
                dvs_pkg::DVS_WACK: begin
                    if (scl_fall && !r_r.drive_low) begin
                        // Byte complete: index first, then data
                        r_nxt.drive_low = 1'b1;
                        if (!r_r.got_idx) begin
                            r_nxt.idx = r_r.shift;
                            r_nxt.got_idx = 1'b1;
                        end else if (r_r.idx == dvs_pkg::IDX_FIRST_DATA) begin
                            r_nxt.sel = r_r.shift;
                            r_nxt.wr_count = r_r.wr_count + 8'h01;
                        end
                    end else if (scl_fall) begin
                        r_nxt.drive_low = 1'b0;
                        r_nxt.bitc = 3'h0;
                        r_nxt.fsm = dvs_pkg::DVS_WBYTE;
                    end
                end
                dvs_pkg::DVS_RBYTE: begin
                    if (scl_fall) begin
                        r_nxt.bitc = r_r.bitc + 3'h1;
                        r_nxt.shift = {r_r.shift[6:0], 1'b0};
                        if (r_r.bitc == 3'h7) begin
                            r_nxt.drive_low = 1'b0;
                            r_nxt.fsm = dvs_pkg::DVS_RACK;
                        end else begin
                            r_nxt.drive_low = ~r_r.shift[6];
                        end
                    end
                end
                dvs_pkg::DVS_RACK: begin
                    if (scl_rise) begin
                        // Host ack repeats the byte, nack ends the transfer
                        r_nxt.fsm = sda_in ? dvs_pkg::DVS_IDLE : dvs_pkg::DVS_ADDR_ACK;
                    end
                end
                default: begin
                    r_nxt.fsm = dvs_pkg::DVS_IDLE;
                end
            endcase
        end

        // AXI write channel capture
        if (s_axi_awvalid && !r_r.aw_hold) begin
            r_nxt.aw_hold = 1'b1;
            r_nxt.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !r_r.w_hold) begin
            r_nxt.w_hold = 1'b1;
            r_nxt.w_data = s_axi_wdata;
            r_nxt.w_strb = s_axi_wstrb;
        end
        if (r_r.aw_hold && r_r.w_hold && !r_r.bvalid) begin
            r_nxt.aw_hold = 1'b0;
            r_nxt.w_hold = 1'b0;
            r_nxt.bvalid = 1'b1;
            r_nxt.bresp = dvs_pkg::RESP_OKAY;
            if (r_r.aw_addr == dvs_pkg::AXI_SEL) begin
                if (r_r.w_strb[0]) begin
                    r_nxt.sel = r_r.w_data[7:0];
                end
            end else if (r_r.aw_addr == dvs_pkg::AXI_CFG) begin
                if (r_r.w_strb[0]) begin
                    r_nxt.cfg_en = r_r.w_data[0];
                end
            end else if (r_r.aw_addr != dvs_pkg::AXI_STAT) begin
                r_nxt.bresp = dvs_pkg::RESP_SLVERR;
            end
        end
        if (r_r.bvalid && s_axi_bready) begin
            r_nxt.bvalid = 1'b0;
        end

        // AXI read channel
        if (s_axi_arvalid && !r_r.rvalid) begin
            r_nxt.rvalid = 1'b1;
            r_nxt.rresp = dvs_pkg::RESP_OKAY;
            r_nxt.rdata = 32'h0000_0000;
            if (s_axi_araddr == dvs_pkg::AXI_SEL) begin
                r_nxt.rdata = {24'h00_0000, r_r.sel};
            end else if (s_axi_araddr == dvs_pkg::AXI_STAT) begin
                r_nxt.rdata = {16'h0000, r_r.wr_count, 1'b0, addr_pin, range_high,
                    r_r.fsm != dvs_pkg::DVS_IDLE, 1'b0, channel_supply_output};
            end else if (s_axi_araddr == dvs_pkg::AXI_CFG) begin
                r_nxt.rdata = {31'h0000_0000, r_r.cfg_en};
            end else begin
                r_nxt.rresp = dvs_pkg::RESP_SLVERR;
            end
        end
        if (r_r.rvalid && s_axi_rready) begin
            r_nxt.rvalid = 1'b0;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            r_r <= '0;
            r_r.fsm <= dvs_pkg::DVS_IDLE;
            r_r.scl_d <= 1'b1;
            r_r.sda_d <= 1'b1;
            r_r.sel <= dvs_pkg::FIRST_DATA_RST;
            r_r.cfg_en <= 1'b1;
        end else begin
            r_r <= r_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Outputs
    assign sda_out = 1'b0;
    assign sda_oe = r_r.drive_low;
    assign s_axi_awready = ~r_r.aw_hold;
    assign s_axi_wready = ~r_r.w_hold;
    assign s_axi_bvalid = r_r.bvalid;
    assign s_axi_bresp = r_r.bresp;
    assign s_axi_arready = ~r_r.rvalid;
    assign s_axi_rvalid = r_r.rvalid;
    assign s_axi_rdata = r_r.rdata;
    assign s_axi_rresp = r_r.rresp;

endmodule

// File: hw/dvs_pkg.sv
package dvs_pkg;

    // Seven-bit slave addresses chosen by the address pin level
    localparam logic [6:0] ADDR_PIN_LOW = 7'h08;
    localparam logic [6:0] ADDR_PIN_HIGH = 7'h09;

    // Direction bit values following the address
    localparam logic DIR_READ = 1'h1;
    localparam logic DIR_WRITE = 1'h0;

    // Layout of the first data register: channel A low nibble, channel B high nibble
    localparam int CH_A_LSB = 0;
    localparam int CH_B_LSB = 4;
    localparam int FIELD_W = 4;
    localparam int RANGE_BIT = 3;

    // Register indexes inside the device, selected by the sub-address byte
    localparam logic [7:0] IDX_FIRST_DATA = 8'h00;

    // Reset value of the first data register: both channels in standby
    localparam logic [7:0] FIRST_DATA_RST = 8'h00;

    // Voltage select codes
    localparam logic [3:0] CODE_STANDBY = 4'h0;
    localparam logic [3:0] CODE_LOW_MIN = 4'h1;
    localparam logic [3:0] CODE_LOW_MAX = 4'h4;
    localparam logic [3:0] CODE_HIGH_MIN = 4'h8;
    localparam logic [3:0] CODE_HIGH_MAX = 4'hb;

    // AXI4-Lite register map (byte addresses)
    localparam logic [3:0] AXI_SEL = 4'h0;
    localparam logic [3:0] AXI_STAT = 4'h4;
    localparam logic [3:0] AXI_CFG = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Serial slave states
    typedef enum logic [2:0] {
        DVS_IDLE,
        DVS_ADDR,
        DVS_ADDR_ACK,
        DVS_WBYTE,
        DVS_WACK,
        DVS_RBYTE,
        DVS_RACK
    } dvs_state_t;

endpackage

// File: bench/dvs_assertions.sv
`timescale 1ns/10ps
module dvs_assertions (
    input wire logic clk,
    input wire logic srst,
    input wire logic sda_oe,
    input wire logic [1:0] channel_supply_output,
    input wire logic [1:0] range_high,
    input wire logic [3:0] level_index_a,
    input wire logic [3:0] level_index_b,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_idle_quiet_a: assert property (!channel_supply_output[0] |-> !range_high[0] && level_index_a == 4'h0)
        else $error("Channel A off but range or level set");
    a_idle_quiet_b: assert property (!channel_supply_output[1] |-> !range_high[1] && level_index_b == 4'h0)
        else $error("Channel B off but range or level set");
    a_level_span: assert property (level_index_a <= 4'h3 && level_index_b <= 4'h3)
        else $error("Level index beyond four levels");
    a_range_needs_on: assert property (|(range_high & ~channel_supply_output) == 1'b0)
        else $error("High range flagged on a disabled channel");
    a_sel_cause: assert property ($changed({channel_supply_output, range_high, level_index_a, level_index_b})
        && !$past(srst) |-> s_axi_bvalid || sda_oe) else $error("Outputs moved without a write");
    a_bvalid_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("Write response repeated");
    a_read_turn: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("Read answer late");
    a_rvalid_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("Read answer repeated");
    a_bad_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 4'hc
        |=> s_axi_rresp == dvs_pkg::RESP_SLVERR && s_axi_rdata == 32'h0) else $error("Unmapped read not refused");
endmodule
bind dvs_top dvs_assertions i_dvs_assertions (.*);

// File: bench/dvs_i2c_host.sv
`timescale 1ns/10ps
// Serial host: SCL driven, SDA pulled low or released (pull-up)
module dvs_i2c_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // Quarter bit: four clocks keeps every level well over two clocks
    task automatic q();
        repeat (4) @(posedge clk);
    endtask
    task automatic start_bit();
        sda_low <= 1'h1;
        q();
        scl <= 1'h0;
        q();
    endtask
    task automatic stop_bit();
        sda_low <= 1'h1;
        q();
        scl <= 1'h1;
        q();
        sda_low <= 1'h0;
        q();
    endtask
    // One bit: drive b while SCL low, sample line mid high phase
    task automatic xbit(input logic b, output logic r);
        sda_low <= !b;
        q();
        scl <= 1'h1;
        q();
        r = sda;
        q();
        scl <= 1'h0;
        q();
    endtask
    // Byte MSB first, then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] o, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], o[i]);
        end
        xbit(ack_in, r);
        ack = !r;
    endtask
    task automatic write_sel(input logic [6:0] a, input logic [7:0] idx, input logic [7:0] d, output logic ok);
        logic [7:0] o;
        logic k1;
        logic k2;
        logic k3;
        start_bit();
        xbyte({a, dvs_pkg::DIR_WRITE}, 1'h1, o, k1);
        xbyte(idx, 1'h1, o, k2);
        xbyte(d, 1'h1, o, k3);
        stop_bit();
        ok = k1 && k2 && k3;
    endtask
    // Single byte read, ended by a not-acknowledge
    task automatic read_sel(input logic [6:0] a, output logic [7:0] d, output logic ok);
        logic k;
        start_bit();
        xbyte({a, dvs_pkg::DIR_READ}, 1'h1, d, ok);
        xbyte(8'hff, 1'h1, d, k);
        stop_bit();
    endtask
endmodule

// File: bench/dvs_top_bench.sv
`timescale 1ns/10ps
module dvs_top_bench;
    logic clk = 1'h0;
    logic srst = 1'h1;
    logic scl_in;
    logic host_low;
    logic sda_in;
    logic sda_out;
    logic sda_oe;
    logic addr_pin = 1'h0;
    logic [1:0] channel_supply_output;
    logic [1:0] range_high;
    logic [3:0] level_index_a;
    logic [3:0] level_index_b;
    logic [3:0] s_axi_awaddr = 4'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'h1;
    logic [3:0] s_axi_araddr = 4'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'h1;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    // Open-drain wire with pull-up
    assign sda_in = !(host_low || (sda_oe && !sda_out));
    dvs_top i_dvs_top (.*);
    dvs_i2c_host i_dvs_i2c_host (.clk(clk), .sda(sda_in), .scl(scl_in), .sda_low(host_low));
    always #20 clk = ~clk;
    task automatic close_out();
        $display("checks_done %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected {enabled, high range, level} of one code
    function automatic logic [3:0] exp_ch(input logic [3:0] c);
        if (c >= 4'h1 && c <= 4'h4) return {2'b10, 2'(c - 4'h1)};
        if (c >= 4'h8 && c <= 4'hb) return {2'b11, c[1:0]};
        return 4'h0;
    endfunction
    task automatic chk_outs(input logic [7:0] s);
        logic [3:0] ea;
        logic [3:0] eb;
        ea = exp_ch(s[3:0]);
        eb = exp_ch(s[7:4]);
        chk(32'({channel_supply_output, range_high, level_index_a, level_index_b}),
            32'({eb[3], ea[3], eb[2], ea[2], 2'h0, ea[1:0], 2'h0, eb[1:0]}));
    endtask
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        r = s_axi_bresp;
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        forever begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
    endtask
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [7:0] b;
        logic ok;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        axi_rd(4'h0, d, r);
        chk(d, 32'h0);
        chk_outs(8'h00);
        // Every code on A, its complement on B
        for (int c = 0; c < 16; c++) begin
            axi_wr(4'h0, 32'({4'(15 - c), 4'(c)}), 4'h1, r);
            @(posedge clk);
            chk_outs({4'(15 - c), 4'(c)});
        end
        axi_wr(4'h0, 32'ha1, 4'h0, r);
        axi_rd(4'h0, d, r);
        chk(d, 32'h0f);
        axi_wr(4'hc, 32'h11, 4'hf, r);
        chk(32'(r), 32'(dvs_pkg::RESP_SLVERR));
        axi_rd(4'hc, d, r);
        chk(32'(r), 32'(dvs_pkg::RESP_SLVERR));
        // Serial writes, pin low then high
        i_dvs_i2c_host.write_sel(7'h08, 8'h00, 8'h9a, ok);
        chk(32'(ok), 32'h1);
        chk_outs(8'h9a);
        i_dvs_i2c_host.write_sel(7'h09, 8'h00, 8'h21, ok);
        chk(32'(ok), 32'h0);
        chk_outs(8'h9a);
        addr_pin <= 1'h1;
        @(posedge clk);
        i_dvs_i2c_host.write_sel(7'h09, 8'h00, 8'h13, ok);
        chk(32'(ok), 32'h1);
        chk_outs(8'h13);
        i_dvs_i2c_host.write_sel(7'h08, 8'h00, 8'h44, ok);
        chk(32'(ok), 32'h0);
        i_dvs_i2c_host.read_sel(7'h09, b, ok);
        chk(32'({ok, b}), 32'h113);
        axi_rd(4'h4, d, r);
        chk(d, 32'h0000_0243);
        axi_wr(4'h4, 32'hff, 4'hf, r);
        chk(32'(r), 32'(dvs_pkg::RESP_OKAY));
        // Reset in mid-run puts both channels back to standby
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        axi_rd(4'h0, d, r);
        chk(d, 32'h0);
        chk_outs(8'h00);
        // Serial port disabled, then enabled again
        axi_rd(4'h8, d, r);
        chk(d, 32'h1);
        axi_wr(4'h8, 32'h0, 4'h1, r);
        i_dvs_i2c_host.write_sel(7'h09, 8'h00, 8'h33, ok);
        chk(32'(ok), 32'h0);
        chk_outs(8'h00);
        axi_wr(4'h8, 32'h1, 4'h1, r);
        i_dvs_i2c_host.write_sel(7'h09, 8'h00, 8'h33, ok);
        chk(32'(ok), 32'h1);
        chk_outs(8'h33);
        close_out();
    end
endmodule
